// file: verilog/fbc_pkg.sv
// fbc_pkg: constants and types for the flash boot and rewrite controller
package fbc_pkg;

  // ------------
  // register offsets on the plain register port
  // ------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h01;
  localparam logic [7:0] REG_ADDR_LO = 8'h02;
  localparam logic [7:0] REG_ADDR_HI = 8'h03;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h05;
  localparam logic [7:0] REG_IRQ_MASK = 8'h06;
  localparam logic [7:0] REG_MODE = 8'h07;

  // ------------
  // control register fields
  // ------------
  localparam int CTRL_READY = 0;
  localparam int CTRL_REWRITE = 1;
  localparam int CTRL_TOP_EN = 2;
  localparam int CTRL_FRESET = 3;
  localparam int CTRL_USER_SEL = 5;
  localparam int CTRL_PERR = 6;
  localparam int CTRL_EERR = 7;

  // status register read by the read-status command
  localparam int SR_READY = 7;
  localparam int SR_EERR = 5;
  localparam int SR_PERR = 4;

  // event bits of the interrupt status register
  localparam int EV_DONE = 0;
  localparam int EV_PERR = 1;
  localparam int EV_EERR = 2;
  localparam int EV_REJECT = 3;
  localparam int EV_W = 4;

  // ------------
  // command codes
  // ------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_BLOCK_ERASE = 8'h20;

  // ------------
  // address map, pins, timing
  // ------------
  localparam logic [15:0] TOP_BLOCK_BASE = 16'hc000;
  localparam logic [15:0] BOOT_VEC_LO = 16'hfffc;
  localparam logic [15:0] BOOT_VEC_HI = 16'hfffd;
  localparam logic [11:0] BOOT_AREA_MASK = 12'hfff;
  localparam logic [1:0] PGM_NONE = 2'h0;
  localparam logic [1:0] PGM_PARALLEL = 2'h1;
  localparam logic [1:0] PGM_SERIAL = 2'h2;
  localparam int PIN_W = 6;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {ACC_NONE, ACC_PARALLEL, ACC_SERIAL, ACC_CPU} fbc_acc_t;
  typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} fbc_state_t;
  typedef enum logic {RM_ARRAY, RM_STATUS} fbc_rmode_t;

endpackage : fbc_pkg

// file: verilog/fbc_pin_sync.sv
// fbc_pin_sync: three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module fbc_pin_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [fbc_pkg::PIN_W-1:0] pin,
  output logic [fbc_pkg::PIN_W-1:0] level
);

  logic [fbc_pkg::PIN_W-1:0] s1;
  logic [fbc_pkg::PIN_W-1:0] s2;
  logic [fbc_pkg::PIN_W-1:0] s3;

  genvar i;
  generate
    for (i = 0; i < fbc_pkg::PIN_W; i = i + 1)
    begin : g_bit
      // stages run through reset so a strap held across it is settled at release
      always_ff @(posedge clk)
      begin
        if (ce)
        begin
          s1[i] <= pin[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
        end
      end
      always_ff @(posedge clk)
      begin
        if (rst)
          level[i] <= 1'b0;
        else if (ce && s2[i] == s3[i])
          level[i] <= s3[i];
      end
    end
  endgenerate

endmodule : fbc_pin_sync
`default_nettype wire

// file: verilog/fbc_flash_ctrl.sv
// fbc_flash_ctrl: flash command sequencer, boot selection and rewrite protection
//
// Contract
// [RL1] three access modes: parallel programmer, serial programmer, CPU rewrite
// [RL2] program and erase start only from commands; five command codes exist
// [RL3] boot area is one 4 KB erase unit; user blocks erase separately
// [RL4] array read protection applies in programmer modes only
// [RL5] boot area is writable only in parallel programmer mode
// [RL6] boot select low at reset: normal mode, run from user area
// [RL7] boot select and strap high at reset: boot mode, vector at top addresses
// [RL8] in boot mode the user area can be rewritten
// [RL9] custom boot program present disables serial programmer mode
// [RL10] block erase address is the block's highest address
// [RL11] CPU rewrite mode may modify only the user area
// [RL12] no direct CPU array reads while rewrite mode is on
// [RL13] each byte programmed at most once between erasures
// [RL14] after erase error, clear status and retry erase at least three times
// [RL15] software tracks erase counts per block and spreads writes
// [RL16] rewrite bit sets only by zero then one written back to back
// [RL17] ready flag low during program or erase, high otherwise
// [RL18] read-array command enters array read mode until another command
// [RL19] rewrite-mode program or erase aimed at boot area is ignored
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_ctrl
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic boot_select_pin,
  input wire logic boot_strap_pin,
  input wire logic [1:0] pgm_mode_pin,
  input wire logic boot_custom_pin,
  input wire logic rom_protect_pin,
  input wire logic pgm_we,
  input wire logic pgm_re,
  input wire logic pgm_boot,
  input wire logic [15:0] pgm_addr,
  input wire logic [7:0] pgm_wdata,
  output logic [7:0] pgm_rdata,
  output logic [15:0] fl_addr,
  output logic fl_boot,
  output logic [7:0] fl_wdata,
  output logic fl_prog,
  output logic fl_erase,
  input wire logic [7:0] fl_rdata,
  input wire logic fl_done,
  input wire logic fl_fail,
  output logic boot_mode,
  output logic fetch_enable,
  output logic fetch_from_boot,
  output logic [15:0] vec_addr_lo,
  output logic [15:0] vec_addr_hi,
  output logic ready_busy_flag,
  output logic irq
);

  // ------------
  // pin synchronisers and strap capture
  // ------------
  logic [fbc_pkg::PIN_W-1:0] pins;
  logic sel_s;
  logic strap_s;
  logic [1:0] pmode_s;
  logic custom_s;
  logic protect_s;
  logic [1:0] strap_cnt;
  logic strap_done;

  fbc_pin_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .pin({rom_protect_pin, boot_custom_pin, pgm_mode_pin, boot_strap_pin, boot_select_pin}),
    .level(pins)
  );

  assign sel_s = pins[0];
  assign strap_s = pins[1];
  assign pmode_s = pins[3:2];
  assign custom_s = pins[4];
  assign protect_s = pins[5];

  // straps settle through the synchroniser before they are caught
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_cnt <= 2'h0;
      strap_done <= 1'b0;
      boot_mode <= 1'b0;
    end
    else if (ce && !strap_done)
    begin
      if (strap_cnt == fbc_pkg::STRAP_WAIT)
      begin
        strap_done <= 1'b1;
        boot_mode <= sel_s && strap_s; // RL6 RL7
      end
      else
        strap_cnt <= strap_cnt + 2'h1;
    end
  end

  // ------------
  // control register
  // ------------
  logic rewrite_sel;
  logic rw_armed;
  logic top_en;
  logic freset;
  logic user_sel;
  logic perr;
  logic eerr;
  logic [15:0] addr_reg;
  logic [fbc_pkg::EV_W-1:0] ev_stat;
  logic [fbc_pkg::EV_W-1:0] ev_mask;
  logic ctrl_wr;

  assign ctrl_wr = reg_we && (reg_addr == fbc_pkg::REG_CTRL);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rewrite_sel <= 1'b0;
      rw_armed <= 1'b0;
      top_en <= 1'b0;
      freset <= 1'b0;
      user_sel <= 1'b0;
    end
    else if (ce)
    begin
      // any other write between the zero and the one breaks the arming
      if (reg_we)
        rw_armed <= ctrl_wr && !reg_wdata[fbc_pkg::CTRL_REWRITE]; // RL16
      if (ctrl_wr)
      begin
        if (!reg_wdata[fbc_pkg::CTRL_REWRITE])
          rewrite_sel <= 1'b0; // RL16
        else if (rw_armed)
          rewrite_sel <= 1'b1; // RL16
        top_en <= reg_wdata[fbc_pkg::CTRL_TOP_EN];
        freset <= reg_wdata[fbc_pkg::CTRL_FRESET];
        // area switch only means something in boot mode
        user_sel <= reg_wdata[fbc_pkg::CTRL_USER_SEL] && boot_mode;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      addr_reg <= 16'h0000;
    else if (ce && reg_we)
    begin
      if (reg_addr == fbc_pkg::REG_ADDR_LO)
        addr_reg[7:0] <= reg_wdata;
      else if (reg_addr == fbc_pkg::REG_ADDR_HI)
        addr_reg[15:8] <= reg_wdata;
    end
  end

  // ------------
  // access mode and command source
  // ------------
  fbc_pkg::fbc_acc_t acc;
  logic host_pgm;
  logic ctl_reset;
  logic pend;
  logic pend_erase;
  logic c_first;
  logic c_second;
  logic [7:0] c_code;
  logic [15:0] c_addr;
  logic [7:0] c_data;
  logic c_boot;
  logic c_allowed;
  fbc_pkg::fbc_state_t state;
  fbc_pkg::fbc_rmode_t rmode;

  always_comb
  begin
    if (pmode_s == fbc_pkg::PGM_PARALLEL)
      acc = fbc_pkg::ACC_PARALLEL; // RL1
    else if (pmode_s == fbc_pkg::PGM_SERIAL && !custom_s)
      acc = fbc_pkg::ACC_SERIAL; // RL1 RL9
    else if (rewrite_sel)
      acc = fbc_pkg::ACC_CPU; // RL1
    else
      acc = fbc_pkg::ACC_NONE;
  end

  assign host_pgm = (acc == fbc_pkg::ACC_PARALLEL) || (acc == fbc_pkg::ACC_SERIAL);
  assign ctl_reset = freset && rewrite_sel;

  // first cycle carries the command code, second the address and data
  assign c_first = host_pgm ? (pgm_we && !pend)
                 : (acc == fbc_pkg::ACC_CPU && reg_we && reg_addr == fbc_pkg::REG_CMD); // RL2
  assign c_second = host_pgm ? (pgm_we && pend)
                  : (acc == fbc_pkg::ACC_CPU && pend && reg_we && reg_addr == fbc_pkg::REG_DATA);
  assign c_code = host_pgm ? pgm_wdata : reg_wdata;
  assign c_addr = host_pgm ? pgm_addr : addr_reg; // RL10
  assign c_data = host_pgm ? pgm_wdata : reg_wdata;
  assign c_boot = host_pgm ? pgm_boot : (boot_mode && !user_sel);

  always_comb
  begin
    if (c_boot)
      c_allowed = (acc == fbc_pkg::ACC_PARALLEL); // RL5 RL11 RL19
    else if (acc == fbc_pkg::ACC_CPU && c_addr >= fbc_pkg::TOP_BLOCK_BASE)
      c_allowed = top_en;
    else
      c_allowed = 1'b1; // RL8
  end

  // ------------
  // command sequencer
  // ------------
  logic start_prog;
  logic start_erase;
  logic op_end;
  logic reject;

  assign start_prog = c_second && !pend_erase && c_allowed && state == fbc_pkg::ST_IDLE;
  assign start_erase = c_second && pend_erase && c_allowed && state == fbc_pkg::ST_IDLE;
  assign op_end = state != fbc_pkg::ST_IDLE && fl_done;
  assign reject = c_second && !(start_prog || start_erase);

  always_ff @(posedge clk)
  begin
    if (rst || ctl_reset)
    begin
      state <= fbc_pkg::ST_IDLE;
      pend <= 1'b0;
      pend_erase <= 1'b0;
    end
    else if (ce)
    begin
      if (c_second)
        pend <= 1'b0;
      else if (c_first && (c_code == fbc_pkg::CMD_PROGRAM || c_code == fbc_pkg::CMD_BLOCK_ERASE))
      begin
        pend <= 1'b1;
        pend_erase <= (c_code == fbc_pkg::CMD_BLOCK_ERASE);
      end
      case (state)
        fbc_pkg::ST_IDLE:
        begin
          if (start_prog)
            state <= fbc_pkg::ST_PROG; // RL2
          else if (start_erase)
            state <= fbc_pkg::ST_ERASE; // RL2 RL3
        end
        default:
        begin
          if (fl_done)
            state <= fbc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // read mode follows the latest command; starting an operation shows status
  always_ff @(posedge clk)
  begin
    if (rst || ctl_reset)
      rmode <= fbc_pkg::RM_ARRAY;
    else if (ce)
    begin
      if (c_first && c_code == fbc_pkg::CMD_READ_ARRAY)
        rmode <= fbc_pkg::RM_ARRAY; // RL18
      else if (c_first && c_code == fbc_pkg::CMD_READ_STATUS)
        rmode <= fbc_pkg::RM_STATUS;
      else if (start_prog || start_erase)
        rmode <= fbc_pkg::RM_STATUS;
    end
  end

  // error flags: a failure in the same cycle as clear keeps the flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      perr <= 1'b0;
      eerr <= 1'b0;
    end
    else if (ce)
    begin
      if (op_end && fl_fail && state == fbc_pkg::ST_PROG)
        perr <= 1'b1;
      else if (c_first && c_code == fbc_pkg::CMD_CLEAR_STATUS)
        perr <= 1'b0;
      if (op_end && fl_fail && state == fbc_pkg::ST_ERASE)
        eerr <= 1'b1; // RL14
      else if (c_first && c_code == fbc_pkg::CMD_CLEAR_STATUS)
        eerr <= 1'b0; // RL14
    end
  end

  // ------------
  // flash array port
  // ------------
  // the array has no overwrite guard; single programming per erase is up to software
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fl_addr <= 16'h0000;
      fl_boot <= 1'b0;
      fl_wdata <= fbc_pkg::RESET_BYTE;
      fl_prog <= 1'b0;
      fl_erase <= 1'b0;
    end
    else if (ce)
    begin
      fl_prog <= start_prog; // RL13
      fl_erase <= start_erase; // RL3 RL10
      if (state == fbc_pkg::ST_IDLE)
      begin
        fl_addr <= c_addr;
        fl_boot <= c_boot;
        if (start_prog)
          fl_wdata <= c_data;
      end
    end
  end

  assign ready_busy_flag = (state == fbc_pkg::ST_IDLE); // RL17

  // ------------
  // boot fetch control
  // ------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fetch_enable <= 1'b0;
      fetch_from_boot <= 1'b0;
    end
    else if (ce)
    begin
      fetch_enable <= strap_done && !rewrite_sel; // RL12
      fetch_from_boot <= boot_mode && !user_sel; // RL6 RL7
    end
  end

  assign vec_addr_lo = fbc_pkg::BOOT_VEC_LO; // RL7
  assign vec_addr_hi = fbc_pkg::BOOT_VEC_HI; // RL7

  // ------------
  // interrupt status and mask
  // ------------
  logic [fbc_pkg::EV_W-1:0] ev_set;
  logic [fbc_pkg::EV_W-1:0] ev_clr;

  always_comb
  begin
    ev_set = '0;
    ev_set[fbc_pkg::EV_DONE] = op_end;
    ev_set[fbc_pkg::EV_PERR] = op_end && fl_fail && state == fbc_pkg::ST_PROG;
    ev_set[fbc_pkg::EV_EERR] = op_end && fl_fail && state == fbc_pkg::ST_ERASE;
    ev_set[fbc_pkg::EV_REJECT] = reject; // RL19
    ev_clr = (reg_we && reg_addr == fbc_pkg::REG_IRQ_STAT) ? reg_wdata[fbc_pkg::EV_W-1:0] : '0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ev_stat <= '0;
      ev_mask <= '0;
    end
    else if (ce)
    begin
      ev_stat <= (ev_stat & ~ev_clr) | ev_set;
      if (reg_we && reg_addr == fbc_pkg::REG_IRQ_MASK)
        ev_mask <= reg_wdata[fbc_pkg::EV_W-1:0];
    end
  end

  assign irq = |(ev_stat & ev_mask);

  // ------------
  // read paths
  // ------------
  logic [7:0] status_byte;
  logic [7:0] ctrl_byte;
  logic [7:0] data_byte;

  always_comb
  begin
    status_byte = '0;
    status_byte[fbc_pkg::SR_READY] = ready_busy_flag;
    status_byte[fbc_pkg::SR_EERR] = eerr;
    status_byte[fbc_pkg::SR_PERR] = perr;
    ctrl_byte = '0;
    ctrl_byte[fbc_pkg::CTRL_READY] = ready_busy_flag; // RL17
    ctrl_byte[fbc_pkg::CTRL_REWRITE] = rewrite_sel;
    ctrl_byte[fbc_pkg::CTRL_TOP_EN] = top_en;
    ctrl_byte[fbc_pkg::CTRL_FRESET] = freset;
    ctrl_byte[fbc_pkg::CTRL_USER_SEL] = user_sel;
    ctrl_byte[fbc_pkg::CTRL_PERR] = perr;
    ctrl_byte[fbc_pkg::CTRL_EERR] = eerr;
    // CPU rewrite mode reads the array only through the command path, unprotected
    data_byte = (rmode == fbc_pkg::RM_ARRAY) ? fl_rdata : status_byte; // RL4 RL18
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      reg_rdata <= fbc_pkg::RESET_BYTE;
    else if (ce)
    begin
      if (!reg_re)
        reg_rdata <= fbc_pkg::RESET_BYTE;
      else if (reg_addr == fbc_pkg::REG_CTRL)
        reg_rdata <= ctrl_byte;
      else if (reg_addr == fbc_pkg::REG_ADDR_LO)
        reg_rdata <= addr_reg[7:0];
      else if (reg_addr == fbc_pkg::REG_ADDR_HI)
        reg_rdata <= addr_reg[15:8];
      else if (reg_addr == fbc_pkg::REG_DATA)
        reg_rdata <= (acc == fbc_pkg::ACC_CPU) ? data_byte : fbc_pkg::RESET_BYTE; // RL12
      else if (reg_addr == fbc_pkg::REG_IRQ_STAT)
        reg_rdata <= {{(8 - fbc_pkg::EV_W){1'b0}}, ev_stat};
      else if (reg_addr == fbc_pkg::REG_IRQ_MASK)
        reg_rdata <= {{(8 - fbc_pkg::EV_W){1'b0}}, ev_mask};
      else if (reg_addr == fbc_pkg::REG_MODE)
        reg_rdata <= {3'h0, strap_done, boot_mode, rmode == fbc_pkg::RM_STATUS, acc};
      else
        reg_rdata <= fbc_pkg::RESET_BYTE;
    end
  end

  // programmer reads: protected code reads back as zero
  always_ff @(posedge clk)
  begin
    if (rst)
      pgm_rdata <= fbc_pkg::RESET_BYTE;
    else if (ce)
    begin
      if (!pgm_re || !host_pgm)
        pgm_rdata <= fbc_pkg::RESET_BYTE;
      else if (rmode == fbc_pkg::RM_STATUS)
        pgm_rdata <= status_byte;
      else if (protect_s)
        pgm_rdata <= fbc_pkg::RESET_BYTE; // RL4
      else
        pgm_rdata <= fl_rdata;
    end
  end

endmodule : fbc_flash_ctrl
`default_nettype wire

// file: testbench/fbc_flash_ctrl_chk.sv
// fbc_flash_ctrl_chk: port-level checks for the flash controller
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_ctrl_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] pgm_mode_pin,
  input wire logic [15:0] fl_addr,
  input wire logic fl_boot,
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic fl_done,
  input wire logic [15:0] vec_addr_lo,
  input wire logic [15:0] vec_addr_hi,
  input wire logic ready_busy_flag
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    fl_prog || fl_erase;
  endsequence

  sequence s_finish;
    ce && fl_done && !ready_busy_flag;
  endsequence

  a_start_busy: assert property (s_start |-> !ready_busy_flag)
    else $error("ready high at start");
  a_done_ready: assert property (s_finish |=> ready_busy_flag)
    else $error("ready not back");
  a_busy_hold: assert property (ce && !ready_busy_flag && !fl_done |=> !ready_busy_flag && $stable(fl_addr))
    else $error("busy left early or address moved");
  a_busy_cause: assert property ($fell(ready_busy_flag) |-> s_start)
    else $error("busy without start");
  a_pulse_once: assert property (s_start |=> !fl_prog && !fl_erase)
    else $error("start pulse too long");
  a_one_op: assert property (!(fl_prog && fl_erase))
    else $error("program and erase together");
  a_boot_guard: assert property (s_start ##0 fl_boot |-> pgm_mode_pin == fbc_pkg::PGM_PARALLEL)
    else $error("boot write outside parallel mode");
  a_vec_fixed: assert property (vec_addr_lo == fbc_pkg::BOOT_VEC_LO && vec_addr_hi == fbc_pkg::BOOT_VEC_HI)
    else $error("vector addresses wrong");
endmodule : fbc_flash_ctrl_chk

bind fbc_flash_ctrl fbc_flash_ctrl_chk chk_u
(
  .clk(clk),
  .rst(rst),
  .ce(ce),
  .pgm_mode_pin(pgm_mode_pin),
  .fl_addr(fl_addr),
  .fl_boot(fl_boot),
  .fl_prog(fl_prog),
  .fl_erase(fl_erase),
  .fl_done(fl_done),
  .vec_addr_lo(vec_addr_lo),
  .vec_addr_hi(vec_addr_hi),
  .ready_busy_flag(ready_busy_flag)
);
`default_nettype wire

// file: testbench/fbc_flash_model.sv
// fbc_flash_model: behavioural flash array answering program and erase pulses
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] fl_addr,
  input wire logic [7:0] fl_wdata,
  input wire logic fl_prog,
  input wire logic fl_erase,
  input wire logic force_fail,
  output logic [7:0] fl_rdata,
  output logic fl_done,
  output logic fl_fail
);
  localparam int LAT = 5;
  logic [7:0] mem [0:255];
  int cnt;
  logic bad;

  initial
  begin
    fl_done = 1'b0;
    fl_fail = 1'b0;
    cnt = 0;
    bad = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'hff;
  end

  assign fl_rdata = mem[fl_addr[7:0]];

  // an overwrite of a programmed byte fails, as real cells would
  always @(posedge clk)
  begin
    fl_done <= 1'b0;
    fl_fail <= 1'b0;
    if (rst)
      cnt <= 0;
    else if (fl_prog || fl_erase)
    begin
      cnt <= LAT;
      bad <= force_fail || (fl_prog && mem[fl_addr[7:0]] != 8'hff);
      if (fl_prog)
        mem[fl_addr[7:0]] <= fl_wdata;
      else
        for (int i = 0; i < 256; i++)
          mem[i] <= 8'hff;
    end
    else if (cnt == 1)
    begin
      fl_done <= 1'b1;
      fl_fail <= bad;
      cnt <= 0;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule : fbc_flash_model
`default_nettype wire

// file: testbench/tb_top.sv
// tb_top: self-checking bench for the flash controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} fbc_row_t;
  logic clk, rst, ce, reg_we, reg_re, boot_select_pin, boot_strap_pin, boot_custom_pin, rom_protect_pin;
  logic pgm_we, pgm_re, pgm_boot, fl_boot, fl_prog, fl_erase, fl_done, fl_fail, force_fail;
  logic boot_mode, fetch_enable, fetch_from_boot, ready_busy_flag, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pgm_wdata, pgm_rdata, fl_wdata, fl_rdata;
  logic [15:0] pgm_addr, fl_addr, vec_addr_lo, vec_addr_hi;
  logic [1:0] pgm_mode_pin;
  int n_mismatch = 0;
  int comparisons = 0;
  fbc_row_t rows [8] = '{'{fbc_pkg::REG_IRQ_MASK, 8'h0f, 8'h0f}, '{fbc_pkg::REG_IRQ_MASK, 8'h00, 8'h00},
    '{8'h08, 8'haa, 8'h00}, '{8'hff, 8'h55, 8'h00}, '{fbc_pkg::REG_DATA, 8'h12, 8'h00},
    '{fbc_pkg::REG_IRQ_STAT, 8'hff, 8'h00}, '{fbc_pkg::REG_MODE, 8'hff, 8'h10}, '{fbc_pkg::REG_CTRL, 8'h02, 8'h01}};

  fbc_flash_ctrl dut_u (.clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .boot_select_pin(boot_select_pin),
    .boot_strap_pin(boot_strap_pin), .pgm_mode_pin(pgm_mode_pin), .boot_custom_pin(boot_custom_pin),
    .rom_protect_pin(rom_protect_pin), .pgm_we(pgm_we), .pgm_re(pgm_re), .pgm_boot(pgm_boot),
    .pgm_addr(pgm_addr), .pgm_wdata(pgm_wdata), .pgm_rdata(pgm_rdata), .fl_addr(fl_addr), .fl_boot(fl_boot),
    .fl_wdata(fl_wdata), .fl_prog(fl_prog), .fl_erase(fl_erase), .fl_rdata(fl_rdata), .fl_done(fl_done),
    .fl_fail(fl_fail), .boot_mode(boot_mode), .fetch_enable(fetch_enable), .fetch_from_boot(fetch_from_boot),
    .vec_addr_lo(vec_addr_lo), .vec_addr_hi(vec_addr_hi), .ready_busy_flag(ready_busy_flag), .irq(irq));

  fbc_flash_model mdl_u (.clk(clk), .rst(rst), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_prog(fl_prog),
    .fl_erase(fl_erase), .force_fail(force_fail), .fl_rdata(fl_rdata), .fl_done(fl_done), .fl_fail(fl_fail));

  // ------------
  // compare and bus tasks
  // ------------
  task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_v

  task automatic chk_b(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_b

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    reg_re <= 1'b0;
    @(posedge clk);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    reg_addr <= a;
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    chk_v(nm, {8'h00, e}, {8'h00, reg_rdata});
    @(posedge clk);
  endtask : rd

  task automatic pw(input logic [7:0] d, input logic [15:0] a, input logic b);
    pgm_wdata <= d;
    pgm_addr <= a;
    pgm_boot <= b;
    pgm_we <= 1'b1;
    @(posedge clk);
  endtask : pw

  task automatic stop;
    reg_we <= 1'b0;
    pgm_we <= 1'b0;
    @(negedge clk);
  endtask : stop

  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    wr(fbc_pkg::REG_CMD, c);
    wr(fbc_pkg::REG_ADDR_LO, a[7:0]);
    wr(fbc_pkg::REG_ADDR_HI, a[15:8]);
    wr(fbc_pkg::REG_DATA, d);
    stop();
  endtask : op

  task automatic wait_rdy;
    for (int n = 0; n < 50 && ready_busy_flag !== 1'b1; n++)
      @(posedge clk);
    chk_b("ready", 1'b1, ready_busy_flag);
  endtask : wait_rdy

  // pins are asynchronous: hold them long enough for the synchroniser
  task automatic pins(input logic [1:0] m, input logic p, input logic s, input logic t);
    reg_we <= 1'b0;
    pgm_we <= 1'b0;
    pgm_mode_pin <= m;
    rom_protect_pin <= p;
    boot_select_pin <= s;
    boot_strap_pin <= t;
    repeat (8) @(posedge clk);
  endtask : pins

  task automatic rst_dut;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : rst_dut

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results

  // ------------
  // clock, watchdog, test sequence
  // ------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("mismatch watchdog expected end seen hang");
    results();
  end

  initial
  begin
    {rst, ce, reg_we, reg_re, pgm_we, pgm_re, pgm_boot} = 7'h60;
    {boot_select_pin, boot_strap_pin, boot_custom_pin, rom_protect_pin, force_fail} = 5'h00;
    {reg_addr, reg_wdata, pgm_wdata, pgm_addr, pgm_mode_pin} = 42'h0;
    rst_dut();
    chk_b("ready", 1'b1, ready_busy_flag);
    chk_b("boot_mode", 1'b0, boot_mode);
    chk_b("fetch_from_boot", 1'b0, fetch_from_boot);
    chk_b("fetch_enable", 1'b1, fetch_enable);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "row");
    end
    $display("test registers done");
    wr(fbc_pkg::REG_CTRL, 8'h00);
    wr(fbc_pkg::REG_CTRL, 8'h02);
    rd(fbc_pkg::REG_CTRL, 8'h03, "ctrl");
    chk_b("fetch_enable", 1'b0, fetch_enable);
    rd(fbc_pkg::REG_MODE, 8'h13, "mode");
    wr(fbc_pkg::REG_IRQ_MASK, 8'h01);
    op(fbc_pkg::CMD_PROGRAM, 16'h2010, 8'h5a);
    chk_b("prog", 1'b1, fl_prog);
    chk_v("prog_addr", 16'h2010, fl_addr);
    chk_v("prog_data", 16'h005a, {8'h00, fl_wdata});
    chk_b("ready", 1'b0, ready_busy_flag);
    wait_rdy();
    rd(fbc_pkg::REG_IRQ_STAT, 8'h01, "irq_stat");
    chk_b("irq", 1'b1, irq);
    wr(fbc_pkg::REG_IRQ_STAT, 8'h01);
    rd(fbc_pkg::REG_IRQ_STAT, 8'h00, "irq_stat");
    chk_b("irq", 1'b0, irq);
    $display("test cpu program done");
    for (int i = 0; i < 3; i++)
    begin
      force_fail <= (i == 0);
      op(fbc_pkg::CMD_BLOCK_ERASE, 16'h2fff, 8'hd0);
      chk_b("erase", 1'b1, fl_erase);
      chk_v("erase_addr", 16'h2fff, fl_addr);
      wait_rdy();
      rd(fbc_pkg::REG_CTRL, (i == 0) ? 8'h83 : 8'h03, "ctrl_err");
      wr(fbc_pkg::REG_CMD, fbc_pkg::CMD_CLEAR_STATUS);
    end
    rd(fbc_pkg::REG_CTRL, 8'h03, "ctrl_clr");
    wr(fbc_pkg::REG_IRQ_STAT, 8'hff);
    $display("test erase retry done");
    pins(fbc_pkg::PGM_PARALLEL, 1'b0, 1'b0, 1'b0);
    pw(fbc_pkg::CMD_PROGRAM, 16'h0000, 1'b0);
    pw(8'h3c, 16'hfff0, 1'b1);
    stop();
    chk_b("boot_prog", 1'b1, fl_prog);
    chk_b("boot_area", 1'b1, fl_boot);
    wait_rdy();
    pins(fbc_pkg::PGM_PARALLEL, 1'b1, 1'b0, 1'b0);
    pw(fbc_pkg::CMD_READ_ARRAY, 16'h0000, 1'b0);
    pgm_we <= 1'b0;
    pgm_addr <= 16'hfff0;
    pgm_re <= 1'b1;
    @(posedge clk);
    pgm_re <= 1'b0;
    @(negedge clk);
    chk_v("pgm_rdata", 16'h0000, {8'h00, pgm_rdata});
    @(posedge clk);
    wr(fbc_pkg::REG_IRQ_STAT, 8'hff);
    pins(fbc_pkg::PGM_SERIAL, 1'b0, 1'b0, 1'b0);
    pw(fbc_pkg::CMD_PROGRAM, 16'h0000, 1'b0);
    pw(8'h3c, 16'hfff1, 1'b1);
    stop();
    chk_b("serial_boot", 1'b0, fl_prog);
    @(posedge clk);
    rd(fbc_pkg::REG_IRQ_STAT, 8'h08, "reject");
    $display("test programmer done");
    pins(fbc_pkg::PGM_NONE, 1'b0, 1'b1, 1'b1);
    rst_dut();
    chk_b("boot_mode", 1'b1, boot_mode);
    chk_b("fetch_from_boot", 1'b1, fetch_from_boot);
    wr(fbc_pkg::REG_CTRL, 8'h00);
    wr(fbc_pkg::REG_CTRL, 8'h02);
    op(fbc_pkg::CMD_PROGRAM, 16'h3000, 8'h11);
    chk_b("boot_target", 1'b0, fl_prog);
    @(posedge clk);
    rd(fbc_pkg::REG_IRQ_STAT, 8'h08, "reject");
    wr(fbc_pkg::REG_CTRL, 8'h20);
    wr(fbc_pkg::REG_CTRL, 8'h22);
    op(fbc_pkg::CMD_PROGRAM, 16'h3000, 8'h11);
    chk_b("user_prog", 1'b1, fl_prog);
    wait_rdy();
    $display("test boot mode done");
    results();
  end
endmodule : tb_top
`default_nettype wire
